// [design/ras_map.svh]
// Constants for the request-to-send anti-stream and status logic.
// Assumes a 20 MHz clock; included by the package users by bare name.
`ifndef RAS_MAP_SVH
`define RAS_MAP_SVH
`define RAS_CLK_HZ          20000000
`define RAS_SHORT_TMO_MS    12500
`define RAS_LONG_TMO_MS     50000
`define RAS_SHORT_TMO_CYC   ((`RAS_CLK_HZ / 1000) * `RAS_SHORT_TMO_MS)
`define RAS_LONG_TMO_CYC    ((`RAS_CLK_HZ / 1000) * `RAS_LONG_TMO_MS)
`define RAS_ADDR_CTRL       4'h0
`define RAS_ADDR_STATUS     4'h4
`define RAS_ADDR_IRQ_STAT   4'h8
`define RAS_ADDR_IRQ_MASK   4'hC
`define RAS_CTRL_RESET      8'h00
`define RAS_BIT_CARRIER     0
`define RAS_BIT_SEL_HI      1
`define RAS_BIT_SEL_LO      2
`define RAS_BIT_LLB_EN      3
`define RAS_BIT_RLB_EN      4
`define RAS_BIT_MULTIPOINT  5
`define RAS_IRQ_STREAM      0
`define RAS_IRQ_BITERR      1
`endif

// [design/ras_pkg.sv]
// Types for the request-to-send anti-stream and status logic.
// Assumes nothing beyond a SystemVerilog tool.
package ras_pkg;
    typedef enum logic [2:0] {
        RAS_IDLE   = 3'b001,
        RAS_TIMING = 3'b010,
        RAS_STREAM = 3'b100
    } ras_state_e;
    typedef struct packed {
        logic carrier_mode_switch;
        logic stream_timeout_sel_hi;
        logic stream_timeout_sel_lo;
        logic local_loop_request_enable;
        logic remote_loop_request_enable;
        logic multipoint;
    } ras_cfg_s;
    typedef struct packed {
        logic tx_activity_indicator;
        logic rx_green;
        logic rts_green;
        logic carrier_indicator;
        logic test_on;
        logic error_red;
    } ras_led_s;
endpackage : ras_pkg

// [design/ras_top.sv]
// Anti-stream watchdog, carrier keying, test and indicator logic of a line modem.
// Assumes a 20 MHz aclk, AXI4-Lite master, async terminal and panel pins.
// Contract
// - Enabled anti-stream times request-to-send from rise
// - Disabled selection passes request-to-send unlimited
// - Timeout forces internal request-to-send low
// - Timeout raises streaming alarm, error red
// - Dropping request-to-send clears timer and alarm
// - Timeout offers short and long settings
// - Select: off disabled, 01/11 short, 10 long
// - Test mode: bit errors light error red
// - No test: error shows streaming alarm
// - Test indicator lit during pattern or loopback
// - Data indicators follow line levels
// - Request indicator follows terminal request level
// - Carrier detect output, indicator follows it
// - Carrier mode off: carrier continuously on
// - Carrier mode on: carrier keyed by request
// - Loopbacks only in point-to-point operation
// - Loopback from panel or terminal line
// - Terminal local loop needs enable setting
`timescale 1ns/1ps
`include "ras_map.svh"
module ras_top #(
    parameter int unsigned SHORT_CYC = `RAS_SHORT_TMO_CYC,
    parameter int unsigned LONG_CYC  = `RAS_LONG_TMO_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        rts_pin,
    input  wire logic        txd_pin,
    input  wire logic        rxd_pin,
    input  wire logic        line_carrier_pin,
    input  wire logic        bit_error_pin,
    input  wire logic        pattern_test_pin,
    input  wire logic        panel_local_pin,
    input  wire logic        panel_remote_pin,
    input  wire logic        term_local_pin,
    input  wire logic        term_remote_pin,
    output logic             rts_internal,
    output logic             carrier_on,
    output logic             carrier_detect,
    output logic             local_loop,
    output logic             remote_loop,
    output ras_pkg::ras_led_s leds,
    output logic             irq
);
    // Counts below two leave no cycle between start and timeout
    if (SHORT_CYC < 2 || LONG_CYC < 2) begin : g_bad_counts
        $error("Timeout counts too small");
    end

    // Pin synchronisers, ten inputs, two flops each
    logic [9:0] sync1;
    logic [9:0] sync2;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= 10'h000;
            sync2 <= 10'h000;
        end else begin
            sync1 <= {term_remote_pin, term_local_pin, panel_remote_pin, panel_local_pin,
                      pattern_test_pin, bit_error_pin, line_carrier_pin, rxd_pin,
                      txd_pin, rts_pin};
            sync2 <= sync1;
        end
    end
    logic rts_s, txd_s, rxd_s, car_s, berr_s, pat_s, pl_s, pr_s, tl_s, tr_s;
    assign {tr_s, tl_s, pr_s, pl_s, pat_s, berr_s, car_s, rxd_s, txd_s, rts_s} = sync2;

    // Configuration register
    logic [7:0] ctrl;
    ras_pkg::ras_cfg_s cfg;
    assign cfg.carrier_mode_switch        = ctrl[`RAS_BIT_CARRIER];
    assign cfg.stream_timeout_sel_hi      = ctrl[`RAS_BIT_SEL_HI];
    assign cfg.stream_timeout_sel_lo      = ctrl[`RAS_BIT_SEL_LO];
    assign cfg.local_loop_request_enable  = ctrl[`RAS_BIT_LLB_EN];
    assign cfg.remote_loop_request_enable = ctrl[`RAS_BIT_RLB_EN];
    assign cfg.multipoint                 = ctrl[`RAS_BIT_MULTIPOINT];

    function automatic logic [31:0] tmo_limit(input logic hi, input logic lo);
        logic [31:0] r;
        r = 32'h0;
        if (hi && !lo) r = LONG_CYC;
        else if (lo)   r = SHORT_CYC;
        return r;
    endfunction : tmo_limit

    // Shared by the state machine and the request guard so both agree on the edge
    function automatic logic hit_limit(input logic [31:0] cnt, input logic [31:0] lmt);
        return (cnt + 32'h1) >= lmt;
    endfunction : hit_limit

    logic        tmo_enabled;
    logic [31:0] limit;
    assign tmo_enabled = cfg.stream_timeout_sel_hi | cfg.stream_timeout_sel_lo;
    assign limit = tmo_limit(cfg.stream_timeout_sel_hi, cfg.stream_timeout_sel_lo);

    // Anti-stream watchdog
    ras_pkg::ras_state_e state;
    logic [31:0] count;
    logic        stream_alarm;
    logic        stream_event;
    logic        at_limit;
    assign at_limit = hit_limit(count, limit);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state        <= ras_pkg::RAS_IDLE;
            count        <= 32'h0;
            stream_alarm <= 1'b0;
            stream_event <= 1'b0;
        end else begin
            stream_event <= 1'b0;
            case (state)
                ras_pkg::RAS_IDLE: begin
                    count        <= 32'h0;
                    stream_alarm <= 1'b0;
                    if (rts_s && tmo_enabled) state <= ras_pkg::RAS_TIMING;
                end
                ras_pkg::RAS_TIMING: begin
                    if (!rts_s || !tmo_enabled) begin
                        state <= ras_pkg::RAS_IDLE;
                        count <= 32'h0;
                    end else if (at_limit) begin
                        state        <= ras_pkg::RAS_STREAM;
                        stream_alarm <= 1'b1;
                        stream_event <= 1'b1;
                    end else begin
                        count <= count + 32'h1;
                    end
                end
                ras_pkg::RAS_STREAM: begin
                    // Stays latched while the terminal keeps the request up and a timeout stays selected
                    if (!rts_s || !tmo_enabled) begin
                        state        <= ras_pkg::RAS_IDLE;
                        stream_alarm <= 1'b0;
                        count        <= 32'h0;
                    end
                end
                default: state <= ras_pkg::RAS_IDLE;
            endcase
        end
    end

    // Test modes
    logic loop_req_l, loop_req_r, test_active;
    assign loop_req_l = !cfg.multipoint &&
                        (pl_s || (tl_s && cfg.local_loop_request_enable));
    assign loop_req_r = !cfg.multipoint && !loop_req_l &&
                        (pr_s || (tr_s && cfg.remote_loop_request_enable));
    assign test_active = pat_s | local_loop | remote_loop;

    // Outputs and indicators
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rts_internal   <= 1'b0;
            carrier_on     <= 1'b0;
            carrier_detect <= 1'b0;
            local_loop     <= 1'b0;
            remote_loop    <= 1'b0;
            leds           <= '0;
        end else begin
            rts_internal   <= rts_s && (state != ras_pkg::RAS_STREAM) &&
                              !(state == ras_pkg::RAS_TIMING && at_limit);
            // Carrier keyed off the guarded request so a streaming slave drops carrier
            carrier_on     <= cfg.carrier_mode_switch ? rts_internal : 1'b1;
            carrier_detect <= car_s;
            local_loop     <= loop_req_l;
            remote_loop    <= loop_req_r;
            leds.tx_activity_indicator <= txd_s;
            leds.rx_green              <= rxd_s;
            leds.rts_green             <= rts_s;
            leds.carrier_indicator     <= carrier_detect;
            leds.test_on               <= pat_s | loop_req_l | loop_req_r;
            leds.error_red             <= test_active ? berr_s : stream_alarm;
        end
    end

    // Interrupt status and mask
    logic [1:0] irq_stat, irq_mask;
    logic       berr_event, berr_d;
    logic       wr_go, rd_go, wr_strb0;
    logic [3:0] wr_addr;
    logic [31:0] wr_data;
    assign berr_event = test_active && berr_s && !berr_d;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= 2'h0;
            berr_d   <= 1'b0;
            irq      <= 1'b0;
        end else begin
            berr_d <= berr_s;
            // Set beats clear in the same cycle
            irq_stat <= (irq_stat & ~((wr_go && wr_addr == `RAS_ADDR_IRQ_STAT && wr_strb0)
                                      ? wr_data[1:0] : 2'h0))
                        | {berr_event, stream_event};
            irq <= |(irq_stat & irq_mask);
        end
    end

    // AXI4-Lite slave: write
    logic aw_held, w_held;
    logic [3:0] aw_q;
    logic [31:0] w_q;
    logic [3:0] ws_q;
    assign wr_addr = aw_held ? aw_q : s_axi_awaddr;
    assign wr_data = w_held ? w_q : s_axi_wdata;
    // A held data beat keeps its own strobe; the live one may already have moved
    assign wr_strb0 = w_held ? ws_q[0] : s_axi_wstrb[0];
    assign wr_go = (aw_held || (s_axi_awvalid && s_axi_awready)) &&
                   (w_held || (s_axi_wvalid && s_axi_wready)) && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_q          <= 4'h0;
            w_q           <= 32'h0;
            ws_q          <= 4'h0;
            ctrl          <= `RAS_CTRL_RESET;
            irq_mask      <= 2'h0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready && !wr_go) begin
                aw_held <= 1'b1;
                aw_q    <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready && !wr_go) begin
                w_held <= 1'b1;
                w_q    <= s_axi_wdata;
                ws_q   <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'h0;
                if (wr_strb0) begin
                    case (wr_addr)
                        `RAS_ADDR_CTRL:     ctrl <= wr_data[7:0];
                        `RAS_ADDR_IRQ_MASK: irq_mask <= wr_data[1:0];
                        `RAS_ADDR_STATUS, `RAS_ADDR_IRQ_STAT: ;
                        default:            s_axi_bresp <= 2'h2;
                    endcase
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite slave: read
    assign rd_go = s_axi_arvalid && s_axi_arready;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'h0;
                case (s_axi_araddr)
                    `RAS_ADDR_CTRL:     s_axi_rdata <= {24'h0, ctrl};
                    `RAS_ADDR_STATUS:   s_axi_rdata <= {24'h0, stream_alarm, rts_internal,
                                                        carrier_on, local_loop, remote_loop,
                                                        test_active, carrier_detect, rts_s};
                    `RAS_ADDR_IRQ_STAT: s_axi_rdata <= {30'h0, irq_stat};
                    `RAS_ADDR_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Checks
    a_stream_forces_low: assert property (@(posedge aclk) disable iff (!aresetn)
        stream_alarm |-> ##1 !rts_internal) else $error("Request passed while streaming");
    a_alarm_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == ras_pkg::RAS_STREAM && !rts_s) |=> !stream_alarm)
        else $error("Alarm not cleared on drop");
    a_disabled_passes: assert property (@(posedge aclk) disable iff (!aresetn)
        (!tmo_enabled && rts_s) |-> state == ras_pkg::RAS_IDLE || $past(tmo_enabled))
        else $error("Timer ran while disabled");
    a_rts_passes: assert property (@(posedge aclk) disable iff (!aresetn)
        (!tmo_enabled && state == ras_pkg::RAS_IDLE) |=> rts_internal == $past(rts_s))
        else $error("Request not passed while disabled");
    a_alarm_at_limit: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(stream_alarm) |-> $past(count) + 32'h1 >= $past(limit))
        else $error("Alarm before timeout");
    a_error_mux: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> leds.error_red == ($past(test_active) ? $past(berr_s) : $past(stream_alarm)))
        else $error("Error indicator wrong source");
    a_carrier_cont: assert property (@(posedge aclk) disable iff (!aresetn)
        !cfg.carrier_mode_switch ##1 !$past(cfg.carrier_mode_switch) |-> carrier_on)
        else $error("Carrier dropped in continuous mode");
    a_keyed_carrier: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg.carrier_mode_switch |=> carrier_on == $past(rts_internal))
        else $error("Carrier not keyed by request");
    a_no_mp_loop: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(cfg.multipoint) |-> !local_loop && !remote_loop)
        else $error("Loopback in multipoint");
    a_llb_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        (!pl_s && !cfg.local_loop_request_enable) |=> !local_loop)
        else $error("Local loop not gated");
    a_test_led: assert property (@(posedge aclk) disable iff (!aresetn)
        (local_loop || remote_loop) |-> leds.test_on)
        else $error("Test indicator dark during loopback");
    a_carrier_led: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> leds.carrier_indicator == $past(carrier_detect))
        else $error("Carrier indicator does not follow output");
    a_reset_clears: assert property (@(posedge aclk)
        !aresetn |=> !stream_alarm && !leds.error_red && state == ras_pkg::RAS_IDLE)
        else $error("Reset left alarm set");
    c_stream: cover property (@(posedge aclk) $rose(stream_alarm));
    c_berr_event: cover property (@(posedge aclk) berr_event);
    c_loop: cover property (@(posedge aclk) $rose(local_loop));
    c_keyed: cover property (@(posedge aclk) cfg.carrier_mode_switch && $rose(carrier_on));
endmodule : ras_top

// [sim/ras_dte_model.sv]
// Terminal model: drives request-to-send, transmit data and loop request lines.
// Assumes the bench calls its tasks; lines change just after a rising aclk edge.
`timescale 1ns/1ps
module ras_dte_model (
    input  wire logic aclk,
    output logic      rts_pin,
    output logic      txd_pin,
    output logic      term_local_pin,
    output logic      term_remote_pin
);
    // Serial lines idle low, as a quiet terminal leaves them
    initial begin
        rts_pin = 1'b0;
        txd_pin = 1'b0;
        term_local_pin = 1'b0;
        term_remote_pin = 1'b0;
    end
    task automatic set_lines(input logic rts, input logic txd);
        @(posedge aclk);
        rts_pin <= rts;
        txd_pin <= txd;
    endtask : set_lines
    // Either loop request line may be raised by the terminal
    task automatic set_loop(input logic loc, input logic rem);
        @(posedge aclk);
        term_local_pin <= loc;
        term_remote_pin <= rem;
    endtask : set_loop
endmodule : ras_dte_model

// [sim/rts_antistream_status_logic_tb.sv]
// Bench for the anti-stream watchdog, carrier keying, test and indicator logic.
// Assumes ras_top with short timeouts and a terminal model on the serial side.
`timescale 1ns/1ps
`include "ras_map.svh"
module rts_antistream_status_logic_tb;
    localparam int SHORT = 20;
    localparam int LONG  = 80;
    logic              aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic              s_axi_rvalid, s_axi_rready, rts_pin, txd_pin, rxd_pin;
    logic              line_carrier_pin, bit_error_pin, pattern_test_pin, irq;
    logic              panel_local_pin, panel_remote_pin, term_local_pin, term_remote_pin;
    logic              rts_internal, carrier_on, carrier_detect, local_loop, remote_loop;
    logic [3:0]        s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0]       s_axi_wdata, s_axi_rdata, rd;
    logic [1:0]        s_axi_bresp, s_axi_rresp, resp;
    ras_pkg::ras_led_s leds;
    int                bad_count, checks_done;
    int                lim [4] = '{0, SHORT, LONG, SHORT};
    // Short counts keep each timeout to 20 or 80 cycles
    ras_top #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rts_pin(rts_pin),
        .txd_pin(txd_pin), .rxd_pin(rxd_pin), .line_carrier_pin(line_carrier_pin),
        .bit_error_pin(bit_error_pin), .pattern_test_pin(pattern_test_pin),
        .panel_local_pin(panel_local_pin), .panel_remote_pin(panel_remote_pin),
        .term_local_pin(term_local_pin), .term_remote_pin(term_remote_pin),
        .rts_internal(rts_internal), .carrier_on(carrier_on), .carrier_detect(carrier_detect),
        .local_loop(local_loop), .remote_loop(remote_loop), .leds(leds), .irq(irq));
    ras_dte_model dte_u (.aclk(aclk), .rts_pin(rts_pin), .txd_pin(txd_pin),
        .term_local_pin(term_local_pin), .term_remote_pin(term_remote_pin));
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : wait_cyc
    // Outputs are registered, so values read just after an edge are the sampled ones
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        int   n;
        logic done;
        n = 0;
        done = 1'b0;
        r = 2'h3;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done && n < 100) begin
            @(posedge aclk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                done = 1'b1;
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
        if (!done) begin
            bad_count++;
            $display("ERROR at %0t: write response never came", $time);
            finish_test();
        end
    endtask : axi_write
    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int   n;
        logic done;
        n = 0;
        done = 1'b0;
        d = 32'h0;
        r = 2'h3;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done && n < 100) begin
            @(posedge aclk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                done = 1'b1;
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
        end
        if (!done) begin
            bad_count++;
            $display("ERROR at %0t: read data never came", $time);
            finish_test();
        end
    endtask : axi_read
    task automatic loop_case(input logic [31:0] ctrl, input logic [3:0] p, input logic [1:0] e);
        axi_write(`RAS_ADDR_CTRL, ctrl, resp);
        dte_u.set_loop(p[1], p[0]);
        panel_local_pin <= p[3];
        panel_remote_pin <= p[2];
        wait_cyc(6);
        chk({local_loop, remote_loop}, e, "loop outputs");
        chk(leds.test_on, |e, "test led");
    endtask : loop_case
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        {rxd_pin, line_carrier_pin, bit_error_pin, pattern_test_pin} = '0;
        {panel_local_pin, panel_remote_pin} = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        chk(leds.error_red, 1'b0, "error after reset");
        axi_read(`RAS_ADDR_CTRL, rd, resp);
        chk(rd, {24'h0, `RAS_CTRL_RESET}, "ctrl reset");
        axi_read(`RAS_ADDR_STATUS, rd, resp);
        chk(rd & 32'h80, 32'h0, "alarm after reset");
        axi_read(4'h2, rd, resp);
        chk(resp, 2'h2, "unmapped read");
        axi_write(4'h6, 32'hFF, resp);
        chk(resp, 2'h2, "unmapped write");
        for (int v = 0; v < 2; v++) begin
            dte_u.set_lines(v[0], v[0]);
            rxd_pin <= v[0];
            line_carrier_pin <= v[0];
            wait_cyc(6);
            chk({leds.tx_activity_indicator, leds.rx_green}, {2{v[0]}}, "data leds");
            chk(leds.rts_green, v[0], "rts led");
            chk({carrier_detect, leds.carrier_indicator}, {2{v[0]}}, "carrier detect");
            chk(carrier_on, 1'b1, "continuous carrier");
            axi_write(`RAS_ADDR_CTRL, 32'h1 << `RAS_BIT_CARRIER, resp);
            wait_cyc(4);
            chk(carrier_on, v[0], "keyed carrier");
            axi_write(`RAS_ADDR_CTRL, 32'h0, resp);
        end
        for (int k = 0; k < 4; k++) begin
            axi_write(`RAS_ADDR_CTRL, (32'(k[1]) << `RAS_BIT_SEL_HI) |
                (32'(k[0]) << `RAS_BIT_SEL_LO), resp);
            dte_u.set_lines(1'b1, 1'b0);
            if (lim[k] == 0) begin
                wait_cyc(LONG + 20);
                chk(rts_internal, 1'b1, "unlimited rts");
            end else begin
                wait_cyc(lim[k] - 6);
                chk(rts_internal, 1'b1, "rts before limit");
                wait_cyc(14);
                chk(rts_internal, 1'b0, "rts forced low");
                chk(leds.error_red, 1'b1, "stream alarm");
                axi_read(`RAS_ADDR_STATUS, rd, resp);
                chk(rd & 32'hC0, 32'h80, "status alarm");
            end
            dte_u.set_lines(1'b0, 1'b0);
            wait_cyc(6);
            chk({leds.error_red, rts_internal}, 2'h0, "alarm cleared");
        end
        chk(irq, 1'b0, "masked irq");
        axi_read(`RAS_ADDR_IRQ_STAT, rd, resp);
        chk(rd[`RAS_IRQ_STREAM], 1'b1, "stream event");
        axi_write(`RAS_ADDR_IRQ_MASK, 32'h1 << `RAS_IRQ_STREAM, resp);
        wait_cyc(3);
        chk(irq, 1'b1, "irq raised");
        axi_write(`RAS_ADDR_IRQ_STAT, 32'h1 << `RAS_IRQ_STREAM, resp);
        wait_cyc(3);
        chk(irq, 1'b0, "irq cleared");
        bit_error_pin <= 1'b1;
        wait_cyc(6);
        chk({leds.error_red, leds.test_on}, 2'h0, "bit error outside test");
        pattern_test_pin <= 1'b1;
        wait_cyc(6);
        chk({leds.error_red, leds.test_on}, 2'h3, "bit error in test");
        // A fresh error edge inside the test is what raises the event bit
        bit_error_pin <= 1'b0;
        wait_cyc(4);
        bit_error_pin <= 1'b1;
        wait_cyc(6);
        axi_read(`RAS_ADDR_IRQ_STAT, rd, resp);
        chk(rd[1:0], 2'h2, "bit error event");
        bit_error_pin <= 1'b0;
        pattern_test_pin <= 1'b0;
        loop_case(32'h0, 4'h8, 2'h2);
        loop_case(32'h0, 4'h4, 2'h1);
        loop_case(32'h1 << `RAS_BIT_MULTIPOINT, 4'h8, 2'h0);
        loop_case(32'h0, 4'h2, 2'h0);
        loop_case(32'h1 << `RAS_BIT_LLB_EN, 4'h2, 2'h2);
        loop_case(32'h1 << `RAS_BIT_RLB_EN, 4'h1, 2'h1);
        loop_case(32'h0, 4'h0, 2'h0);
        loop_case(32'h0, 4'h1, 2'h0);
        axi_write(`RAS_ADDR_CTRL, 32'h1 << `RAS_BIT_SEL_LO, resp);
        dte_u.set_lines(1'b1, 1'b0);
        wait_cyc(SHORT + 10);
        chk(leds.error_red, 1'b1, "alarm before reset");
        // Mid-run reset while streaming must drop the alarm at once
        aresetn <= 1'b0;
        wait_cyc(2);
        aresetn <= 1'b1;
        wait_cyc(2);
        chk({leds.error_red, rts_internal}, 2'h0, "reset clears alarm");
        finish_test();
    end
endmodule : rts_antistream_status_logic_tb
